// *** include/oiw_pkg.sv ***
package oiw_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_OUT3 = 8'h04;
	localparam logic [7:0] OFS_OUT4 = 8'h08;
	localparam logic [7:0] OFS_OUT5 = 8'h0C;
	localparam logic [7:0] OFS_IN1 = 8'h10;
	localparam logic [7:0] OFS_IN2 = 8'h14;
	localparam logic [7:0] OFS_IN6 = 8'h18;
	localparam logic [7:0] OFS_CLK1 = 8'h1C;
	localparam logic [7:0] OFS_CLK2 = 8'h20;
	localparam logic [7:0] OFS_CLK6 = 8'h24;
	localparam logic [7:0] OFS_FILT_FIRST = 8'h28;
	localparam logic [7:0] OFS_FILT_LAST = 8'hB0;
	localparam int FILT_NUM = 35;

	localparam int CB_IRQ_EN = 0;
	localparam int CB_IRQ_SET = 1;
	localparam int CB_GATE3 = 2;
	localparam int CB_GATE4 = 3;
	localparam int CB_RX0_1 = 4;
	localparam int CB_RX0_2 = 5;
	localparam int CB_RX1_1 = 6;
	localparam int CB_RX1_2 = 7;
	localparam int CB_TX0 = 8;
	localparam int CB_RST0 = 9;
	localparam int CB_DBC0 = 10;
	localparam int CB_TX1 = 12;
	localparam int CB_RST1 = 13;
	localparam int CB_DBC1 = 14;
	localparam int CB_DAC_EN = 16;
	localparam int CB_ADC_EN = 17;
	localparam int CB_TCLK = 20;

	localparam int CK_DIV_LSB = 0;
	localparam int CK_DIV_W = 18;
	localparam int CK_OSEL = 18;
	localparam int CK_REF_LSB = 19;
	localparam logic [1:0] CK_REF_PRESCALE = 2'h3;

	localparam int FC_LO_LSB = 0;
	localparam int FC_HI_LSB = 8;
	localparam int FC_RISE = 16;
	localparam int FC_FALL = 17;
	localparam int FC_INV = 18;
	localparam int FC_EN = 19;
	localparam int FC_CLR = 20;

	localparam logic [31:0] MASK_CTRL = 32'h001377FF;
	localparam logic [31:0] MASK_OUT3 = 32'h00006F7F;
	localparam logic [31:0] MASK_OUT4 = 32'h00007FFF;
	localparam logic [31:0] MASK_OUT5 = 32'h00000F3F;
	localparam logic [31:0] MASK_CLK = 32'h001FFFFF;
	localparam logic [31:0] MASK_FILT = 32'h001FFFFF;
	localparam logic [15:0] MASK_IN1 = 16'h1FFF;
	localparam logic [15:0] MASK_IN2 = 16'hFD1F;
	localparam logic [15:0] MASK_IN6 = 16'hE31F;
	localparam logic [31:0] REG_RST = 32'h00000000;

	localparam int RAW_LSB = 16;
	localparam int W4_WARMUP_BIT = 13;
	localparam int W5_CMP_BIT = 4;
	localparam logic [7:0] CNT_MIN = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;

	// Word code in bits 5:4 (0 word 1, 1 word 2, 2 word 6), input number in bits 3:0.
	localparam logic [0:FILT_NUM-1][5:0] FILT_POS = {
		6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B,
		6'h0C, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h18, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E,
		6'h1F, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h28, 6'h29, 6'h2D, 6'h2E, 6'h2F};

	localparam int SYS_CLK_NS = 10;
	localparam int XCVR_RST_LOW_NS = 200;
	localparam int XCVR_RST_LOW_CYC = (XCVR_RST_LOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
endpackage : oiw_pkg

// *** logic/oiw_top.sv ***
// Operation
// - Global control bits are active high and clear to zero on reset.
// - Master interrupt enable gates interrupt requests onto the backplane line.
// - Interrupt force bit with master enable asserts the request regardless.
// - Gate bits at zero let words 3 and 4 drive optocouplers.
// - Receive enable bits drive transceiver receive channels; channel 2 kept zero, but the code passes channel 2 bits 5 and 7 through unmasked.
// - Transmit enable bits let each transceiver send, zero holds it off.
// - Debounce bits pass straight to the transceiver debounce inputs.
// - DAC master enable gates local conversion enables; nothing is held while it is off.
// - ADC master enable gates local conversion enables; nothing is held while it is off.
// - Test clock select routes word 6 sample clock to UART B data.
// - Output word bits set turn optocouplers on via inverted open drain.
// - Word 5 always enabled; bit 4 drives comparator as plain output.
// - Word 4 bit 13 warm-up indicator is on after reset, one turns off.
// - Only the listed output bit positions exist in words 3, 4, 5.
// - Word 1 read gives raw inputs at 28..16 and filtered at 12..0.
// - Word 2 read gives raw at 16+n, filtered at n for used inputs.
// - Word 6 read gives raw at 16+n, filtered at n for used inputs.
// - Reference select picks bus clock, or half of it for code 11.
// - Divider gives 50 percent clock at reference over two times divisor plus two.
// - Output select picks divider output when one, reference when zero.
// - Enabled filter counts up on one, down on zero, saturating; disabled freezes.
// - Filtered bit sets at high threshold, clears only below low threshold.
// - Clear forces count and value to zero; invert complements the sample.
// - Rising and falling enables pulse edge outputs on filtered transitions.
`timescale 1ns/10ps
`default_nettype none
module oiw_top (
	input wire logic sys_clk, // System clock, also the sample reference.
	input wire logic nrst, // Asynchronous reset, active low.
	input wire logic reg_wr, // Register write strobe.
	input wire logic reg_rd, // Register read strobe.
	input wire logic [7:0] reg_addr, // Byte address of the register.
	input wire logic [31:0] reg_wdata, // Write data.
	output logic [31:0] reg_rdata, // Read data, registered.
	output logic reg_rvalid, // Read data valid pulse.
	input wire logic irq_src, // Interrupt sources from status logic.
	output logic irq_o, // Backplane interrupt pin level, always low.
	output logic irq_oe, // Backplane interrupt drive enable.
	input wire logic [12:0] in_w1_n, // Word 1 opto receiver pins.
	input wire logic [15:0] in_w2_n, // Word 2 opto receiver pins.
	input wire logic [15:0] in_w6_n, // Word 6 opto receiver pins.
	output logic [47:0] edge_rise, // Rising edge pulses, word code times 16 plus input.
	output logic [47:0] edge_fall, // Falling edge pulses, same layout.
	output logic [15:0] out_w3_o, // Word 3 open-drain level, always low.
	output logic [15:0] out_w3_oe, // Word 3 drive enables.
	output logic [15:0] out_w4_o, // Word 4 open-drain level, always low.
	output logic [15:0] out_w4_oe, // Word 4 drive enables.
	output logic [15:0] out_w5_o, // Word 5 open-drain level, always low.
	output logic [15:0] out_w5_oe, // Word 5 drive enables.
	output logic cmp_drive, // Comparator input, plain output.
	output logic [3:0] avionics_rx_enable, // Receive enables dev0 ch1, ch2, dev1 ch1, ch2.
	output logic avionics_tx0_enable, // Transmitter 0 enable.
	output logic avionics_tx1_enable, // Transmitter 1 enable.
	output logic avionics_dev0_reset_n, // Transceiver 0 reset, active low.
	output logic avionics_dev1_reset_n, // Transceiver 1 reset, active low.
	output logic avionics_dev0_debounce, // Transceiver 0 debounce control.
	output logic avionics_dev1_debounce, // Transceiver 1 debounce control.
	input wire logic [3:0] dac_local_en, // Per-channel DAC local enables.
	output logic [3:0] dac_start, // Gated DAC conversion enables.
	input wire logic [3:0] adc_local_en, // Per-channel ADC local enables.
	output logic [3:0] adc_start, // Gated ADC conversion enables.
	input wire logic uartb_txd_in, // UART B transmit data from its core.
	output logic uartb_txd_out // UART B transmit data to the line buffer.
);
	function automatic logic is_filt(input logic [7:0] a);
		is_filt = (a >= oiw_pkg::OFS_FILT_FIRST) && (a <= oiw_pkg::OFS_FILT_LAST)
			&& (a[1:0] == 2'h0);
	endfunction : is_filt

	function automatic logic [5:0] filt_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - oiw_pkg::OFS_FILT_FIRST;
		filt_idx = d[7:2];
	endfunction : filt_idx

	logic [31:0] ctrl_q;
	logic [31:0] out3_q;
	logic [31:0] out4_q;
	logic [31:0] out5_q;
	logic [2:0][31:0] clk_q;
	logic [20:0] fctl_q [oiw_pkg::FILT_NUM];
	logic [31:0] rdata_q;
	logic rvalid_q;
	logic [47:0] sync1_q;
	logic [47:0] sync2_q;
	logic [47:0] rise_q;
	logic [47:0] fall_q;
	logic [2:0] tick;
	logic [2:0] sclk_lvl;
	logic [47:0] raw_all;
	logic [47:0] filt_all;
	logic [oiw_pkg::FILT_NUM-1:0] val_q;
	logic [oiw_pkg::FILT_NUM-1:0] prev_q;
	logic [31:0] rd_mux;
	logic [31:0] rd_in1;
	logic [31:0] rd_in2;
	logic [31:0] rd_in6;
	logic wr_filt;
	logic [5:0] wr_fidx;
	logic [5:0] rd_fidx;

	assign wr_filt = reg_wr && is_filt(reg_addr);
	assign wr_fidx = filt_idx(reg_addr);
	assign rd_fidx = filt_idx(reg_addr);

	// Unused control positions are masked off so spare bits read back zero.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= oiw_pkg::REG_RST;
			out3_q <= oiw_pkg::REG_RST;
			out4_q <= oiw_pkg::REG_RST;
			out5_q <= oiw_pkg::REG_RST;
			clk_q <= {3{oiw_pkg::REG_RST}};
		end else if (reg_wr) begin
			unique case (reg_addr)
				oiw_pkg::OFS_CTRL: ctrl_q <= reg_wdata & oiw_pkg::MASK_CTRL;
				oiw_pkg::OFS_OUT3: out3_q <= reg_wdata & oiw_pkg::MASK_OUT3;
				oiw_pkg::OFS_OUT4: out4_q <= reg_wdata & oiw_pkg::MASK_OUT4;
				oiw_pkg::OFS_OUT5: out5_q <= reg_wdata & oiw_pkg::MASK_OUT5;
				oiw_pkg::OFS_CLK1: clk_q[0] <= reg_wdata & oiw_pkg::MASK_CLK;
				oiw_pkg::OFS_CLK2: clk_q[1] <= reg_wdata & oiw_pkg::MASK_CLK;
				oiw_pkg::OFS_CLK6: clk_q[2] <= reg_wdata & oiw_pkg::MASK_CLK;
				default: ;
			endcase
		end
	end

	genvar fw;
	generate
		for (fw = 0; fw < oiw_pkg::FILT_NUM; fw++) begin : g_fctl
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					fctl_q[fw] <= 21'h000000;
				end else if (wr_filt && (wr_fidx == 6'(fw))) begin
					fctl_q[fw] <= reg_wdata[20:0] & oiw_pkg::MASK_FILT[20:0];
				end
			end
		end
	endgenerate

	// Interrupt line is open drain: it is pulled low only while a request stands.
	assign irq_o = 1'b0;
	assign irq_oe = ctrl_q[oiw_pkg::CB_IRQ_EN]
		&& (irq_src || ctrl_q[oiw_pkg::CB_IRQ_SET]);

	assign avionics_rx_enable = ctrl_q[oiw_pkg::CB_RX1_2:oiw_pkg::CB_RX0_1];
	assign avionics_tx0_enable = ctrl_q[oiw_pkg::CB_TX0];
	assign avionics_tx1_enable = ctrl_q[oiw_pkg::CB_TX1];
	// Reset comes up low so the transceivers stay cleared until software releases them.
	assign avionics_dev0_reset_n = ctrl_q[oiw_pkg::CB_RST0];
	assign avionics_dev1_reset_n = ctrl_q[oiw_pkg::CB_RST1];
	assign avionics_dev0_debounce = ctrl_q[oiw_pkg::CB_DBC0];
	assign avionics_dev1_debounce = ctrl_q[oiw_pkg::CB_DBC1];
	// Local enables are levels; they wait here until the master bit lets them through.
	assign dac_start = dac_local_en & {4{ctrl_q[oiw_pkg::CB_DAC_EN]}};
	assign adc_start = adc_local_en & {4{ctrl_q[oiw_pkg::CB_ADC_EN]}};
	assign uartb_txd_out = ctrl_q[oiw_pkg::CB_TCLK] ? sclk_lvl[2] : uartb_txd_in;

	// Optocoupler LEDs are on while the pin is pulled low, hence enable equals bit set.
	assign out_w3_o = 16'h0000;
	assign out_w4_o = 16'h0000;
	assign out_w5_o = 16'h0000;
	assign out_w3_oe = out3_q[15:0] & oiw_pkg::MASK_OUT3[15:0]
		& {16{~ctrl_q[oiw_pkg::CB_GATE3]}};
	// The warm-up LED bit is inverted so the indicator is lit straight out of reset.
	assign out_w4_oe = (out4_q[15:0] ^ (16'h0001 << oiw_pkg::W4_WARMUP_BIT))
		& oiw_pkg::MASK_OUT4[15:0] & {16{~ctrl_q[oiw_pkg::CB_GATE4]}};
	assign out_w5_oe = out5_q[15:0] & oiw_pkg::MASK_OUT5[15:0]
		& ~(16'h0001 << oiw_pkg::W5_CMP_BIT);
	assign cmp_drive = out5_q[oiw_pkg::W5_CMP_BIT];

	// Opto receivers invert, so the synchronised pins are complemented here.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= 48'h000000000000;
			sync2_q <= 48'h000000000000;
		end else begin
			sync1_q <= ~{in_w6_n, in_w2_n, 3'h0, in_w1_n};
			sync2_q <= sync1_q;
		end
	end
	assign raw_all = sync2_q & {oiw_pkg::MASK_IN6, oiw_pkg::MASK_IN2, oiw_pkg::MASK_IN1};

	genvar cw;
	generate
		for (cw = 0; cw < 3; cw++) begin : g_sclk
			logic pre_q;
			logic div_q;
			logic [17:0] cnt_q;
			logic ref_tick;
			logic wrap;
			logic [17:0] divisor;
			logic osel;
			assign divisor = clk_q[cw][oiw_pkg::CK_DIV_LSB +: oiw_pkg::CK_DIV_W];
			assign osel = clk_q[cw][oiw_pkg::CK_OSEL];
			assign ref_tick = (clk_q[cw][oiw_pkg::CK_REF_LSB +: 2] == oiw_pkg::CK_REF_PRESCALE)
				? pre_q : 1'b1;
			assign wrap = ref_tick && (cnt_q >= divisor);
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					pre_q <= 1'b0;
					div_q <= 1'b0;
					cnt_q <= 18'h00000;
				end else begin
					pre_q <= ~pre_q;
					if (wrap) begin
						cnt_q <= 18'h00000;
						div_q <= ~div_q;
					end else if (ref_tick) begin
						cnt_q <= cnt_q + 18'h00001;
					end
				end
			end
			// Inputs are sampled on each rising edge of the chosen sample clock.
			assign tick[cw] = osel ? (wrap && !div_q) : ref_tick;
			assign sclk_lvl[cw] = osel ? div_q : pre_q;
		end
	endgenerate

	genvar fk;
	generate
		for (fk = 0; fk < oiw_pkg::FILT_NUM; fk++) begin : g_filt
			localparam logic [5:0] POS = oiw_pkg::FILT_POS[fk];
			logic [7:0] cnt_q;
			logic [7:0] cnt_d;
			logic smp;
			logic en;
			logic clr;
			logic [7:0] hi;
			logic [7:0] lo;
			assign en = fctl_q[fk][oiw_pkg::FC_EN];
			assign clr = fctl_q[fk][oiw_pkg::FC_CLR];
			assign hi = fctl_q[fk][oiw_pkg::FC_HI_LSB +: 8];
			assign lo = fctl_q[fk][oiw_pkg::FC_LO_LSB +: 8];
			assign smp = raw_all[POS] ^ fctl_q[fk][oiw_pkg::FC_INV];
			// Saturation keeps a noisy line from wrapping the count across thresholds.
			assign cnt_d = smp ? ((cnt_q == oiw_pkg::CNT_MAX) ? cnt_q : cnt_q + 8'h01)
				: ((cnt_q == oiw_pkg::CNT_MIN) ? cnt_q : cnt_q - 8'h01);
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					cnt_q <= 8'h00;
					val_q[fk] <= 1'b0;
				end else if (clr) begin
					cnt_q <= oiw_pkg::CNT_MIN;
					val_q[fk] <= 1'b0;
				end else if (en && tick[POS[5:4]]) begin
					cnt_q <= cnt_d;
					if (cnt_d >= hi) begin
						val_q[fk] <= 1'b1;
					end else if (cnt_d < lo) begin
						val_q[fk] <= 1'b0;
					end
				end
			end
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					prev_q[fk] <= 1'b0;
					rise_q[POS] <= 1'b0;
					fall_q[POS] <= 1'b0;
				end else begin
					prev_q[fk] <= val_q[fk];
					rise_q[POS] <= val_q[fk] && !prev_q[fk] && fctl_q[fk][oiw_pkg::FC_RISE];
					fall_q[POS] <= !val_q[fk] && prev_q[fk] && fctl_q[fk][oiw_pkg::FC_FALL];
				end
			end
		end
	endgenerate

	// Positions with no input have no driver in the edge registers; tie them off.
	genvar ux;
	generate
		for (ux = 0; ux < 48; ux++) begin : g_unused
			if (!(((ux < 16) && oiw_pkg::MASK_IN1[ux % 16])
				|| ((ux >= 16) && (ux < 32) && oiw_pkg::MASK_IN2[ux % 16])
				|| ((ux >= 32) && oiw_pkg::MASK_IN6[ux % 16]))) begin : g_tie
				assign rise_q[ux] = 1'b0;
				assign fall_q[ux] = 1'b0;
			end
		end
	endgenerate
	assign edge_rise = rise_q;
	assign edge_fall = fall_q;

	always_comb begin
		filt_all = 48'h000000000000;
		for (int k = 0; k < oiw_pkg::FILT_NUM; k++) begin
			filt_all[oiw_pkg::FILT_POS[k]] = val_q[k];
		end
	end

	assign rd_in1 = {3'h0, raw_all[12:0], 3'h0, filt_all[12:0]};
	assign rd_in2 = {raw_all[31:16], filt_all[31:16]};
	assign rd_in6 = {raw_all[47:32], filt_all[47:32]};

	always_comb begin
		rd_mux = 32'h00000000;
		if (is_filt(reg_addr)) begin
			rd_mux = {11'h000, fctl_q[rd_fidx]};
		end else begin
			unique case (reg_addr)
				oiw_pkg::OFS_CTRL: rd_mux = ctrl_q;
				oiw_pkg::OFS_OUT3: rd_mux = out3_q;
				oiw_pkg::OFS_OUT4: rd_mux = out4_q;
				oiw_pkg::OFS_OUT5: rd_mux = out5_q;
				oiw_pkg::OFS_IN1: rd_mux = rd_in1;
				oiw_pkg::OFS_IN2: rd_mux = rd_in2;
				oiw_pkg::OFS_IN6: rd_mux = rd_in6;
				oiw_pkg::OFS_CLK1: rd_mux = clk_q[0];
				oiw_pkg::OFS_CLK2: rd_mux = clk_q[1];
				oiw_pkg::OFS_CLK6: rd_mux = clk_q[2];
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 32'h00000000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd;
			if (reg_rd) begin
				rdata_q <= rd_mux;
			end
		end
	end
	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
endmodule : oiw_top
`default_nettype wire

// *** tb/oiw_field.sv ***
`timescale 1ns/10ps
`default_nettype none
module oiw_field (
	input wire logic [12:0] lvl1, // Word 1 field levels.
	input wire logic [15:0] lvl2, // Word 2 field levels.
	input wire logic [15:0] lvl6, // Word 6 field levels.
	output logic [12:0] pin1_n, // Word 1 receiver pins.
	output logic [15:0] pin2_n, // Word 2 receiver pins.
	output logic [15:0] pin6_n // Word 6 receiver pins.
);
	// The receivers are open drain, so an energised input pulls its pin low.
	assign pin1_n = ~lvl1;
	assign pin2_n = ~lvl2;
	assign pin6_n = ~lvl6;
endmodule : oiw_field
`default_nettype wire

// *** tb/oiw_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module oiw_sva (
	input wire logic sys_clk, // Clock.
	input wire logic nrst, // Reset.
	input wire logic reg_wr, // Write.
	input wire logic reg_rd, // Read.
	input wire logic [7:0] reg_addr, // Address.
	input wire logic [31:0] reg_wdata, // Data.
	input wire logic reg_rvalid, // Read valid.
	input wire logic irq_src, // Sources.
	input wire logic irq_oe, // Request.
	input wire logic [47:0] edge_rise, // Rises.
	input wire logic [47:0] edge_fall, // Falls.
	input wire logic [15:0] out_w4_oe, // Word 4.
	input wire logic cmp_drive, // Comparator.
	input wire logic [3:0] avionics_rx_enable, // Rx.
	input wire logic avionics_tx0_enable, // Tx 0.
	input wire logic avionics_tx1_enable, // Tx 1.
	input wire logic avionics_dev0_reset_n, // Reset 0.
	input wire logic avionics_dev1_reset_n, // Reset 1.
	input wire logic avionics_dev0_debounce, // Debounce 0.
	input wire logic avionics_dev1_debounce, // Debounce 1.
	input wire logic [3:0] dac_local_en, // DAC local.
	input wire logic [3:0] dac_start, // DAC start.
	input wire logic [3:0] adc_local_en, // ADC local.
	input wire logic [3:0] adc_start // ADC start.
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	wire ctrl_wr = reg_wr && reg_addr == oiw_pkg::OFS_CTRL;
	wire out5_wr = reg_wr && reg_addr == oiw_pkg::OFS_OUT5;
	// Write data kept one cycle, so each check sees what was actually written.
	logic [31:0] wd_q;
	always_ff @(posedge sys_clk) begin
		wd_q <= reg_wdata;
	end
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("no read answer");
	a_irq_master: assert property (ctrl_wr && !reg_wdata[0] |=> !irq_oe)
		else $error("request with master off");
	a_irq_follow: assert property (ctrl_wr && reg_wdata[1:0] == 2'h1 |=> irq_oe == irq_src)
		else $error("request not following sources");
	a_irq_force: assert property (ctrl_wr && reg_wdata[1:0] == 2'h3 |=> irq_oe)
		else $error("forced request missing");
	a_dac_gate: assert property (ctrl_wr |=> dac_start == (dac_local_en & {4{wd_q[16]}}))
		else $error("dac start wrong");
	a_adc_gate: assert property (ctrl_wr |=> adc_start == (adc_local_en & {4{wd_q[17]}}))
		else $error("adc start wrong");
	a_xcvr_lines: assert property (ctrl_wr |=> {avionics_rx_enable, avionics_dev1_debounce,
		avionics_dev1_reset_n, avionics_tx1_enable, avionics_dev0_debounce, avionics_dev0_reset_n,
		avionics_tx0_enable} == {wd_q[7:4], wd_q[14:12], wd_q[10:8]}) else $error("xcvr lines wrong");
	a_cmp_level: assert property (out5_wr |=> cmp_drive == wd_q[4])
		else $error("comparator level wrong");
	a_edge_apart: assert property ((edge_rise & edge_fall) == 48'h0)
		else $error("rise and fall together");
	a_reset_state: assert property (disable iff (1'b0) !nrst |-> out_w4_oe == 16'h2000 && !irq_oe
		&& !avionics_dev0_reset_n) else $error("reset state wrong");
	c_read: cover property (reg_rvalid);
	c_rise: cover property (|edge_rise);
	c_fall: cover property (|edge_fall);
endmodule : oiw_sva
bind oiw_top oiw_sva i_oiw_sva (.sys_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
	.reg_rvalid, .irq_src, .irq_oe, .edge_rise, .edge_fall, .out_w4_oe, .cmp_drive,
	.avionics_rx_enable, .avionics_tx0_enable, .avionics_tx1_enable, .avionics_dev0_reset_n,
	.avionics_dev1_reset_n, .avionics_dev0_debounce, .avionics_dev1_debounce, .dac_local_en,
	.dac_start, .adc_local_en, .adc_start);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} oiw_row_t;
	typedef struct {logic [31:0] c; logic s; logic [18:0] e;} oiw_ctl_t;
	logic sys_clk = 1'b0, nrst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq_src = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
	logic [3:0] dac_local_en = 4'hA, adc_local_en = 4'h5, dac_start, adc_start;
	logic uartb_txd_in = 1'b0, uartb_txd_out, txd_l = 1'b0;
	logic [12:0] lvl1 = 13'h1555, in_w1_n;
	logic [15:0] lvl2 = 16'hFFFF, lvl6 = 16'hFFFF, in_w2_n, in_w6_n;
	logic [47:0] edge_rise, edge_fall;
	logic [15:0] out_w3_o, out_w3_oe, out_w4_o, out_w4_oe, out_w5_o, out_w5_oe;
	logic [3:0] avionics_rx_enable;
	logic reg_rvalid, irq_o, irq_oe, cmp_drive, avionics_tx0_enable, avionics_tx1_enable;
	logic avionics_dev0_reset_n, avionics_dev1_reset_n, avionics_dev0_debounce, avionics_dev1_debounce;
	int n_fail = 0, total_checks = 0, cyc = 0, n_rise = 0, n_fall = 0;
	int rise_at[$];
	oiw_row_t rows[11] = '{'{8'h00, 32'hFFFFFF5F, 32'h0013775F},
		'{8'h04, 32'hFFFFFFFF, 32'h00006F7F}, '{8'h08, 32'hFFFFFFFF, 32'h00007FFF},
		'{8'h0C, 32'hFFFFFFFF, 32'h00000F3F}, '{8'h1C, 32'hFFFFFFFF, 32'h001FFFFF},
		'{8'h20, 32'hFFFFFFFF, 32'h001FFFFF}, '{8'h24, 32'hFFFFFFFF, 32'h001FFFFF},
		'{8'h28, 32'hFFFFFFFF, 32'h001FFFFF}, '{8'hB0, 32'hFFFFFFFF, 32'h001FFFFF},
		'{8'hB4, 32'hFFFFFFFF, 32'h00000000}, '{8'h0A, 32'hFFFFFFFF, 32'h00000000}};
	oiw_ctl_t ctls[6] = '{'{32'h1, 1'b1, 19'h40000}, '{32'h0, 1'b1, 19'h0},
		'{32'h3, 1'b0, 19'h40000}, '{32'h2, 1'b0, 19'h0},
		'{32'h36751, 1'b0, 19'h2956F}, '{32'h11000, 1'b1, 19'h28010}};
	wire [18:0] ctl_vec = {irq_oe, dac_start, adc_start, avionics_rx_enable, avionics_tx0_enable,
		avionics_tx1_enable, avionics_dev0_reset_n, avionics_dev1_reset_n, avionics_dev0_debounce,
		avionics_dev1_debounce};
	oiw_field i_oiw_field (.lvl1, .lvl2, .lvl6, .pin1_n(in_w1_n), .pin2_n(in_w2_n), .pin6_n(in_w6_n));
	oiw_top i_oiw_top (.sys_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_rvalid, .irq_src, .irq_o, .irq_oe, .in_w1_n, .in_w2_n, .in_w6_n, .edge_rise,
		.edge_fall, .out_w3_o, .out_w3_oe, .out_w4_o, .out_w4_oe, .out_w5_o, .out_w5_oe, .cmp_drive,
		.avionics_rx_enable, .avionics_tx0_enable, .avionics_tx1_enable, .avionics_dev0_reset_n,
		.avionics_dev1_reset_n, .avionics_dev0_debounce, .avionics_dev1_debounce, .dac_local_en,
		.dac_start, .adc_local_en, .adc_start, .uartb_txd_in, .uartb_txd_out);
	always #5 sys_clk = ~sys_clk;
	// Sampled on the falling edge so flop updates on the rising edge never race the count.
	always @(negedge sys_clk) begin
		cyc++;
		if (uartb_txd_out === 1'b1 && txd_l === 1'b0) rise_at.push_back(cyc);
		txd_l = uartb_txd_out;
		if (edge_rise[0] === 1'b1) n_rise++;
		if (edge_fall[0] === 1'b1) n_fall++;
	end
	task automatic close_out;
		if (n_fail == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
		total_checks++;
		if (got !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, e, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge sys_clk);
		#1 reg_wr = 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
		@(posedge sys_clk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge sys_clk);
		#1 reg_rd = 1'b0;
		chk("read valid", 32'h1, {31'h0, reg_rvalid});
		chk(what, e, reg_rdata);
	endtask : rdc
	task automatic per(input logic [31:0] d, input int p);
		wr(8'h24, d);
		repeat (5) @(posedge sys_clk);
		rise_at.delete();
		repeat (70) @(posedge sys_clk);
		chk("clock rises", 32'h1, {31'h0, rise_at.size() > 2});
		chk("clock period", p, rise_at[2] - rise_at[1]);
	endtask : per
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_fail++;
		close_out();
	end
	initial begin
		#1 nrst = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1 chk("warmup in reset", 32'h2000, {16'h0, out_w4_oe});
		chk("xcvr reset in reset", 32'h0, {31'h0, avionics_dev0_reset_n});
		nrst = 1'b1;
		foreach (rows[i]) begin
			rdc(rows[i].a, 32'h0, "reset value");
			wr(rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e, "readback");
		end
		foreach (ctls[i]) begin
			repeat (oiw_pkg::XCVR_RST_LOW_CYC) @(posedge sys_clk);
			#1 irq_src = ctls[i].s;
			wr(8'h00, ctls[i].c);
			chk("ctrl outputs", {13'h0, ctls[i].e}, {13'h0, ctl_vec});
		end
		chk("word 3 drive", 32'h6F7F, {16'h0, out_w3_oe});
		chk("word 4 drive", 32'h5FFF, {16'h0, out_w4_oe});
		chk("word 5 drive", 32'h00010F2F, {15'h0, cmp_drive, out_w5_oe});
		chk("drain levels", 32'h0, {irq_o, out_w3_o, out_w4_o[14:0]} | {16'h0, out_w5_o});
		wr(8'h08, 32'h00000001);
		chk("warmup on", 32'h2001, {16'h0, out_w4_oe});
		wr(8'h00, 32'h0000220C);
		chk("gated", 32'h0, {out_w3_oe, 3'h0, out_w4_oe[12:0]});
		chk("word 5 ungated", 32'h0F2F, {16'h0, out_w5_oe});
		wr(8'h00, 32'h00002200);
		wr(8'h10, 32'hFFFFFFFF);
		rdc(8'h10, 32'h15550000, "word 1");
		rdc(8'h14, 32'hFD1F0000, "word 2");
		rdc(8'h18, 32'hE31F0000, "word 6");
		wr(8'h1C, 32'h00000000);
		wr(8'h28, 32'h000B0402);
		repeat (300) @(posedge sys_clk);
		rdc(8'h10, 32'h15550001, "filter up");
		lvl1[0] = 1'b0;
		repeat (100) @(posedge sys_clk);
		rdc(8'h10, 32'h15540001, "hysteresis");
		repeat (200) @(posedge sys_clk);
		rdc(8'h10, 32'h15540000, "filter down");
		wr(8'h28, 32'h000F0402);
		repeat (20) @(posedge sys_clk);
		rdc(8'h10, 32'h15540001, "inverted");
		wr(8'h28, 32'h00070402);
		lvl1[0] = 1'b1;
		repeat (300) @(posedge sys_clk);
		rdc(8'h10, 32'h15550001, "frozen");
		wr(8'h28, 32'h00140402);
		rdc(8'h10, 32'h15550000, "cleared");
		chk("rise pulses", 32'h2, n_rise);
		chk("fall pulses", 32'h1, n_fall);
		wr(8'h00, 32'h00102200);
		per(32'h00040004, 10);
		per(32'h001C0004, 20);
		per(32'h00000000, 2);
		wr(8'h00, 32'h00002200);
		uartb_txd_in = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 chk("uart pass", 32'h1, {31'h0, uartb_txd_out});
		uartb_txd_in = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 chk("uart pass low", 32'h0, {31'h0, uartb_txd_out});
		close_out();
	end
endmodule : tb
`default_nettype wire
